// ===== tb/adc_monitor_trigger_asserts.sv
`timescale 1ns/1ps
module amt_chk
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// register bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	// events
	input wire adc_monitor_trigger_pkg::conv_result_s conv_result,
	input wire logic adc_soft_reset,
	input wire logic [7:0] conv_clock_setting,
	// hardware start sources, starts and monitor pulses
	input wire logic timer_match_normal,
	input wire logic timer_match_prio,
	input wire logic normal_hw_start,
	input wire logic prio_hw_start,
	input wire logic mon0_irq_pulse,
	input wire logic mon1_irq_pulse
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic rd_acc;
	assign rd_acc = psel && penable && !pwrite;
	chk_mon0_cause: assert property (mon0_irq_pulse |-> $past(conv_result.valid))
		else $error("monitor 0 pulse without result");
	chk_mon1_cause: assert property (mon1_irq_pulse |-> $past(conv_result.valid))
		else $error("monitor 1 pulse without result");
	chk_norm_twice: assert property (normal_hw_start && $past(normal_hw_start) |-> $past(timer_match_normal))
		else $error("normal start repeated");
	chk_prio_twice: assert property (prio_hw_start && $past(prio_hw_start) |-> $past(timer_match_prio))
		else $error("priority start repeated");
	chk_rst_cause: assert property (adc_soft_reset |-> $past(psel && penable && pwrite && paddr == 8'h04 && pwdata[1:0] == 2'h1))
		else $error("soft reset without firing write");
	chk_rst_single: assert property (adc_soft_reset |=> !adc_soft_reset)
		else $error("soft reset longer than one cycle");
	chk_clock_kept: assert property (adc_soft_reset |-> conv_clock_setting == $past(conv_clock_setting, 2))
		else $error("clock setting lost on soft reset");
	chk_trig_zero: assert property (rd_acc && paddr == 8'h04 |-> prdata[31:8] == 24'h0 && prdata[3:0] == 4'h0)
		else $error("trigger unused bits set");
	chk_mon_zero: assert property (rd_acc && (paddr == 8'h00 || paddr == 8'h08) |-> prdata[31:6] == 26'h0)
		else $error("monitor unused bits set");
	chk_res_zero: assert property (rd_acc && paddr[7:6] == 2'h1 |-> prdata[31:16] == 16'h0 && prdata[5:0] == 6'h0)
		else $error("result unused bits set");
	cover property (mon0_irq_pulse);
	cover property (mon1_irq_pulse);
	cover property (prio_hw_start);
	cover property (adc_soft_reset);
endmodule

bind adc_monitor_trigger_ctrl amt_chk u_amt_chk (.*);

// ===== tb/adc_source_model.sv
`timescale 1ns/1ps
module adc_source_model
(
	// clock
	input wire logic pclk,
	// results and start sources
	output adc_monitor_trigger_pkg::conv_result_s conv_result,
	output logic ext_trigger_pin,
	output logic timer_match_normal,
	output logic timer_match_prio
);
	initial
	begin
		conv_result = '0;
		ext_trigger_pin = 1'b0;
		timer_match_normal = 1'b0;
		timer_match_prio = 1'b0;
	end
	// one stored result, valid for a single cycle
	task put(input logic p, input logic [2:0] i, input logic [9:0] d);
		@(posedge pclk);
		conv_result <= {1'b1, p, i, d};
		@(posedge pclk);
		conv_result.valid <= 1'b0;
	endtask
	// timer match on both sources, held for n cycles
	task tmr(input int n);
		@(posedge pclk);
		timer_match_normal <= 1'b1;
		timer_match_prio <= 1'b1;
		repeat (n) @(posedge pclk);
		timer_match_normal <= 1'b0;
		timer_match_prio <= 1'b0;
	endtask
	task ext;
		@(posedge pclk);
		ext_trigger_pin <= 1'b1;
		repeat (8) @(posedge pclk);
		ext_trigger_pin <= 1'b0;
		repeat (8) @(posedge pclk);
	endtask
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hf;
	logic [31:0] prdata, rd;
	logic pready, pslverr, serr, adc_soft_reset, normal_hw_start, prio_hw_start;
	logic mon0_irq_pulse, mon1_irq_pulse, irq, ext_trigger_pin, timer_match_normal, timer_match_prio;
	logic [7:0] conv_clock_setting;
	adc_monitor_trigger_pkg::conv_result_s conv_result;
	int miscompares = 0;
	int checked = 0;
	integer ns = 0;
	integer ps = 0;
	integer rs = 0;
	integer e0, e1;
	logic [7:0] ra [3] = '{8'h00, 8'h04, 8'h08};
	logic [31:0] rm [3] = '{32'h30, 32'hf0, 32'h30};
	always #5 pclk = ~pclk;
	adc_monitor_trigger_ctrl u_adc_monitor_trigger_ctrl (.*);
	adc_source_model u_adc_source_model (.*);
	// start and reset pulse counters
	always @(posedge pclk)
	begin
		ns <= ns + normal_hw_start;
		ps <= ps + prio_hw_start;
		rs <= rs + adc_soft_reset;
	end
	task end_of_test;
		$display("checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
		begin
			miscompares++;
			end_of_test();
		end
	endtask
	task mcase(input logic m, input logic [5:0] c, input logic p, input logic [2:0] i, input logic [9:0] d,
		input logic e);
		xfer(1'b1, m ? 8'h08 : 8'h00, {26'h0, c});
		xfer(1'b1, m ? 8'h00 : 8'h08, 32'h0);
		u_adc_source_model.put(p, i, d);
		#1;
		chk({mon1_irq_pulse, mon0_irq_pulse}, {e & m, e & !m});
		xfer(1'b0, p ? 8'h60 : {3'h2, i, 2'h0}, 32'h0);
		chk(rd, {d, 6'h0});
	endtask
	initial
	begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		// ----------------------------------------
		// registers, monitors, interrupt, triggers, soft reset
		// ----------------------------------------
		for (int k = 0; k < 3; k++)
		begin
			xfer(1'b0, ra[k], 32'h0);
			chk(rd, 32'h0);
			xfer(1'b1, ra[k], 32'hffff_fff0);
			xfer(1'b0, ra[k], 32'h0);
			chk(rd, rm[k]);
		end
		xfer(1'b0, 8'h24, 32'h0);
		chk(serr, 1'b1);
		$display("registers done");
		xfer(1'b1, 8'h0c, 32'h100);
		xfer(1'b1, 8'h10, 32'h100);
		for (int m = 0; m < 2; m++)
		begin
			mcase(m[0], 6'h07, 1'b0, 3'h3, 10'h050, 1'b1);
			mcase(m[0], 6'h07, 1'b0, 3'h3, 10'h100, 1'b0);
			mcase(m[0], 6'h27, 1'b0, 3'h3, 10'h1ff, 1'b1);
			mcase(m[0], 6'h27, 1'b0, 3'h3, 10'h050, 1'b0);
			mcase(m[0], 6'h06, 1'b0, 3'h3, 10'h050, 1'b0);
			mcase(m[0], 6'h07, 1'b0, 3'h4, 10'h050, 1'b0);
			mcase(m[0], 6'h0f, 1'b0, 3'h7, 10'h050, 1'b1);
			mcase(m[0], 6'h15, 1'b1, 3'h0, 10'h050, 1'b1);
			mcase(m[0], 6'h11, 1'b0, 3'h0, 10'h050, 1'b0);
		end
		$display("monitors done");
		xfer(1'b1, 8'h1c, 32'hf);
		mcase(1'b0, 6'h07, 1'b0, 3'h3, 10'h050, 1'b1);
		chk(irq, 1'b0);
		xfer(1'b0, 8'h18, 32'h0);
		chk(rd & 32'h1, 32'h1);
		xfer(1'b1, 8'h20, 32'h1);
		#1;
		chk(irq, 1'b1);
		xfer(1'b1, 8'h1c, 32'h1);
		#1;
		chk(irq, 1'b0);
		$display("interrupt done");
		for (int t = 0; t < 16; t++)
		begin
			if (t[2] && !t[3] && !t[1]) continue;
			xfer(1'b1, 8'h04, t << 4);
			e0 = ns;
			e1 = ps;
			u_adc_source_model.tmr(1);
			repeat (2) @(posedge pclk);
			#1;
			chk(ns - e0, t[0] & t[1]);
			chk(ps - e1, t[2] & t[3]);
			u_adc_source_model.ext();
			chk(ns - e0, t[0]);
			chk(ps - e1, t[2]);
		end
		// timer match held two cycles gives a start on each cycle
		xfer(1'b1, 8'h04, 32'hf0);
		e0 = ns;
		e1 = ps;
		u_adc_source_model.tmr(2);
		repeat (2) @(posedge pclk);
		#1;
		chk(ns - e0, 2);
		chk(ps - e1, 2);
		$display("triggers done");
		xfer(1'b1, 8'h14, 32'h5a);
		xfer(1'b1, 8'h00, 32'h3f);
		xfer(1'b1, 8'h04, 32'h1);
		xfer(1'b1, 8'h04, 32'h2);
		xfer(1'b1, 8'h04, 32'h1);
		repeat (2) @(posedge pclk);
		#1;
		chk(rs, 1);
		xfer(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h0);
		xfer(1'b0, 8'h14, 32'h0);
		chk(rd, 32'h5a);
		chk(conv_clock_setting, 8'h5a);
		$display("soft reset done");
		end_of_test();
	end
endmodule

// ===== verilog/adc_monitor_trigger_ctrl.sv
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "adc_monitor_trigger_regs.svh"

module adc_monitor_trigger_ctrl
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// conversion core
	input wire adc_monitor_trigger_pkg::conv_result_s conv_result,
	output logic adc_soft_reset,
	output logic [`CLKSET_W-1:0] conv_clock_setting,
	// hardware start sources
	input wire logic ext_trigger_pin,
	input wire logic timer_match_normal,
	input wire logic timer_match_prio,
	output logic normal_hw_start,
	output logic prio_hw_start,
	// monitor events and interrupt
	output logic mon0_irq_pulse,
	output logic mon1_irq_pulse,
	output logic irq
);

	// ----------------------------------------
	// functions
	// ----------------------------------------

	// merge write data into the current value, one byte lane per strobe bit
	function automatic logic [31:0] apply_strobe
	(
		input logic [31:0] old_val,
		input logic [31:0] new_val,
		input logic [3:0] strb
	);
		logic [31:0] r;
		r = old_val;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
			begin
				r[i*8 +: 8] = new_val[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// read value of a register; bit 32 flags a mapped address
	function automatic logic [32:0] read_reg
	(
		input adc_monitor_trigger_pkg::state_s st,
		input logic [7:0] addr
	);
		logic [32:0] r;
		r = {1'b1, 32'h0000_0000};
		case (addr)
			`OFF_MON0:
			begin
				r[`MON_CFG_MSB:0] = st.mon0;
			end
			`OFF_TRIG:
			begin
				r[`TRIG_CFG_MSB:`TRIG_CFG_LSB] = st.trig;
			end
			`OFF_MON1:
			begin
				r[`MON_CFG_MSB:0] = st.mon1;
			end
			`OFF_THR0:
			begin
				r[`RES_W-1:0] = st.thr0;
			end
			`OFF_THR1:
			begin
				r[`RES_W-1:0] = st.thr1;
			end
			`OFF_CLKSET:
			begin
				r[`CLKSET_W-1:0] = st.clk_set;
			end
			`OFF_INT_STAT:
			begin
				r[`INT_W-1:0] = st.int_stat;
			end
			`OFF_INT_CLR:
			begin
				r[31:0] = 32'h0000_0000;
			end
			`OFF_INT_EN:
			begin
				r[`INT_W-1:0] = st.int_en;
			end
			`OFF_RES_PRIO:
			begin
				r[`RES_MSB:`RES_LSB] = st.res_prio;
			end
			default:
			begin
				if (addr[7:5] == `RES_NORM_PAGE && addr[1:0] == 2'h0)
				begin
					r[`RES_MSB:`RES_LSB] = st.res_norm[addr[4:2]];
				end
				else
				begin
					r[32] = 1'b0;
				end
			end
		endcase
		return r;
	endfunction

	// monitor hit: enabled, new result lands in the watched register, condition met
	function automatic logic mon_hit
	(
		input adc_monitor_trigger_pkg::mon_cfg_s cfg,
		input adc_monitor_trigger_pkg::result_t thr,
		input adc_monitor_trigger_pkg::conv_result_s cr
	);
		logic targeted;
		logic cond;
		targeted = cfg.sel[3] ? cr.prio : (!cr.prio && cr.index == cfg.sel[2:0]);
		cond = cfg.polarity ? (cr.data > thr) : (cr.data < thr);
		return cr.valid && cfg.enable && targeted && cond;
	endfunction

	// state after soft reset; clock setting and synchroniser passed in
	function automatic adc_monitor_trigger_pkg::state_s reset_state
	(
		input logic [`CLKSET_W-1:0] clk_keep,
		input logic [2:0] sync_keep,
		input logic level_keep
	);
		adc_monitor_trigger_pkg::state_s r;
		r = '0;
		r.mon0 = `MON_CFG_RST;
		r.mon1 = `MON_CFG_RST;
		r.trig = `TRIG_CFG_RST;
		r.rst_seq = adc_monitor_trigger_pkg::RST_IDLE;
		r.thr0 = `THR_RST;
		r.thr1 = `THR_RST;
		r.int_stat = `INT_RST;
		r.int_en = `INT_RST;
		r.res_prio = `RES_RST;
		for (int i = 0; i < `NORM_RES_CNT; i++)
		begin
			r.res_norm[i] = `RES_RST;
		end
		r.clk_set = clk_keep;
		r.ext_sync = sync_keep;
		r.ext_level = level_keep;
		return r;
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	adc_monitor_trigger_pkg::state_s s_q;
	adc_monitor_trigger_pkg::state_s s_d;

	logic [32:0] rd;
	logic [31:0] wval;
	logic wr_en;
	logic setup;
	logic ext_rise;
	logic fire;
	logic [`INT_W-1:0] events;
	logic [`INT_W-1:0] clr;

	// ----------------------------------------
	// next-state logic
	// ----------------------------------------
	always_comb
	begin
		s_d = s_q;
		rd = read_reg(s_q, paddr);
		wval = apply_strobe(rd[31:0], pwdata, pstrb);
		wr_en = psel && penable && pwrite && rd[32];
		setup = psel && !penable;
		fire = 1'b0;
		events = '0;
		clr = '0;

		// single-cycle outputs default low
		s_d.normal_start = 1'b0;
		s_d.prio_start = 1'b0;
		s_d.mon0_pulse = 1'b0;
		s_d.mon1_pulse = 1'b0;
		s_d.soft_rst = 1'b0;

		// external trigger: three stages, level moves once stages two and three agree
		s_d.ext_sync = {s_q.ext_sync[1:0], ext_trigger_pin};
		if (s_q.ext_sync[1] == s_q.ext_sync[2])
		begin
			s_d.ext_level = s_q.ext_sync[2];
		end
		ext_rise = s_q.ext_sync[1] && s_q.ext_sync[2] && !s_q.ext_level;

		// hardware starts; one external edge may feed both paths if software lets it
		s_d.prio_start = s_q.trig.prio_en && (s_q.trig.prio_src ? timer_match_prio : ext_rise);
		s_d.normal_start = s_q.trig.norm_en && (s_q.trig.norm_src ? timer_match_normal : ext_rise);

		// result storage
		if (conv_result.valid)
		begin
			if (conv_result.prio)
			begin
				s_d.res_prio = conv_result.data;
				events[`INT_PRIO_DONE] = 1'b1;
			end
			else
			begin
				s_d.res_norm[conv_result.index] = conv_result.data;
				events[`INT_NORM_DONE] = 1'b1;
			end
		end

		// monitors judge the value being stored this cycle
		events[`INT_MON0] = mon_hit(s_q.mon0, s_q.thr0, conv_result);
		events[`INT_MON1] = mon_hit(s_q.mon1, s_q.thr1, conv_result);
		s_d.mon0_pulse = events[`INT_MON0];
		s_d.mon1_pulse = events[`INT_MON1];

		// apb answer is prepared in the setup cycle
		if (setup)
		begin
			s_d.prdata = pwrite ? s_q.prdata : rd[31:0];
			s_d.pslverr = !rd[32];
		end

		// register writes at the access edge
		if (wr_en)
		begin
			case (paddr)
				`OFF_MON0:
				begin
					s_d.mon0 = wval[`MON_CFG_MSB:0];
				end
				`OFF_MON1:
				begin
					s_d.mon1 = wval[`MON_CFG_MSB:0];
				end
				`OFF_TRIG:
				begin
					s_d.trig = wval[`TRIG_CFG_MSB:`TRIG_CFG_LSB];
					if (pstrb[0])
					begin
						case (s_q.rst_seq)
							adc_monitor_trigger_pkg::RST_IDLE:
							begin
								if (wval[`RST_FIELD_MSB:0] == `RST_ARM_CODE)
								begin
									s_d.rst_seq = adc_monitor_trigger_pkg::RST_ARMED;
								end
							end
							adc_monitor_trigger_pkg::RST_ARMED:
							begin
								if (wval[`RST_FIELD_MSB:0] == `RST_FIRE_CODE)
								begin
									fire = 1'b1;
								end
								else if (wval[`RST_FIELD_MSB:0] != `RST_ARM_CODE)
								begin
									s_d.rst_seq = adc_monitor_trigger_pkg::RST_IDLE;
								end
							end
							default:
							begin
								s_d.rst_seq = adc_monitor_trigger_pkg::RST_IDLE;
							end
						endcase
					end
				end
				`OFF_THR0:
				begin
					s_d.thr0 = wval[`RES_W-1:0];
				end
				`OFF_THR1:
				begin
					s_d.thr1 = wval[`RES_W-1:0];
				end
				`OFF_CLKSET:
				begin
					s_d.clk_set = wval[`CLKSET_W-1:0];
				end
				`OFF_INT_CLR:
				begin
					clr = wval[`INT_W-1:0];
				end
				`OFF_INT_EN:
				begin
					s_d.int_en = wval[`INT_W-1:0];
				end
				default:
				begin
					s_d.int_en = s_q.int_en;
				end
			endcase
		end

		// sticky status, a new event wins over a clear in the same cycle
		s_d.int_stat = (s_q.int_stat & ~clr) | events;

		// soft reset: everything back to reset except the converter clock setting, the external trigger synchroniser and the apb answer
		if (fire)
		begin
			s_d = reset_state(s_q.clk_set, s_d.ext_sync, s_d.ext_level);
			s_d.soft_rst = 1'b1;
			s_d.prdata = s_q.prdata;
			s_d.pslverr = s_q.pslverr;
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_q <= '0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign prdata = s_q.prdata;
	assign pready = 1'b1;
	assign pslverr = s_q.pslverr;
	assign adc_soft_reset = s_q.soft_rst;
	assign conv_clock_setting = s_q.clk_set;
	assign normal_hw_start = s_q.normal_start;
	assign prio_hw_start = s_q.prio_start;
	assign mon0_irq_pulse = s_q.mon0_pulse;
	assign mon1_irq_pulse = s_q.mon1_pulse;
	assign irq = |(s_q.int_stat & s_q.int_en);

endmodule

// ===== verilog/adc_monitor_trigger_pkg.sv
`include "adc_monitor_trigger_regs.svh"

package adc_monitor_trigger_pkg;

	typedef logic [`RES_W-1:0] result_t;

	typedef struct packed
	{
		logic valid;
		logic prio;
		logic [2:0] index;
		result_t data;
	} conv_result_s;

	typedef struct packed
	{
		logic polarity;
		logic [3:0] sel;
		logic enable;
	} mon_cfg_s;

	typedef struct packed
	{
		logic prio_src;
		logic prio_en;
		logic norm_src;
		logic norm_en;
	} trig_cfg_s;

	typedef enum logic [0:0]
	{
		RST_IDLE = 1'b0,
		RST_ARMED = 1'b1
	} rst_seq_e;

	typedef struct packed
	{
		mon_cfg_s mon0;
		mon_cfg_s mon1;
		trig_cfg_s trig;
		rst_seq_e rst_seq;
		result_t thr0;
		result_t thr1;
		logic [`CLKSET_W-1:0] clk_set;
		logic [`INT_W-1:0] int_stat;
		logic [`INT_W-1:0] int_en;
		result_t [`NORM_RES_CNT-1:0] res_norm;
		result_t res_prio;
		logic [2:0] ext_sync;
		logic ext_level;
		logic normal_start;
		logic prio_start;
		logic mon0_pulse;
		logic mon1_pulse;
		logic soft_rst;
		logic [31:0] prdata;
		logic pslverr;
	} state_s;

endpackage

// ===== verilog/adc_monitor_trigger_regs.svh
// Summary of operation
// - monitor 0 enable bit 0 gates monitor 0
// - monitor 0 polarity: 0 below, 1 above threshold
// - monitor 0 selector: 0-7 normal, 1xxx priority
// - monitor 1 enable bit 0 gates monitor 1
// - monitor 1 polarity: 0 below, 1 above threshold
// - monitor 1 selector: 0-7 normal, 1xxx priority
// - trigger bit 7 picks priority start source
// - trigger bit 6 gates priority hardware start
// - trigger bit 5 picks normal start source
// - trigger bit 4 gates normal hardware start
// - writing 10 then 01 fires soft reset
// - soft reset clears all but clock setting, external trigger synchroniser and apb answer
// - priority result holds 10 bits at 15-6
// - normal results at 15-6, rest reads zero
`ifndef ADC_MONITOR_TRIGGER_REGS_SVH
`define ADC_MONITOR_TRIGGER_REGS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define OFF_MON0 8'h00
`define OFF_TRIG 8'h04
`define OFF_MON1 8'h08
`define OFF_THR0 8'h0c
`define OFF_THR1 8'h10
`define OFF_CLKSET 8'h14
`define OFF_INT_STAT 8'h18
`define OFF_INT_CLR 8'h1c
`define OFF_INT_EN 8'h20
`define OFF_RES_PRIO 8'h60
`define RES_NORM_PAGE 3'h2

// ----------------------------------------
// field positions and widths
// ----------------------------------------
`define MON_CFG_MSB 5
`define TRIG_CFG_MSB 7
`define TRIG_CFG_LSB 4
`define RST_FIELD_MSB 1
`define RST_ARM_CODE 2'h2
`define RST_FIRE_CODE 2'h1
`define RES_MSB 15
`define RES_LSB 6
`define RES_W 10
`define NORM_RES_CNT 8
`define CLKSET_W 8
`define INT_W 4
`define INT_MON0 0
`define INT_MON1 1
`define INT_NORM_DONE 2
`define INT_PRIO_DONE 3

// ----------------------------------------
// reset values
// ----------------------------------------
`define MON_CFG_RST 6'h00
`define TRIG_CFG_RST 4'h0
`define THR_RST 10'h000
`define CLKSET_RST 8'h00
`define INT_RST 4'h0
`define RES_RST 10'h000

`endif
